// ===== hdl/hrs_sequencer.sv
`timescale 1ns/100ps
module hrs_sequencer
   import hrs_pkg::*;
#(
   parameter int NUM_PORTS = 4,
   parameter int RECOVERY_CYCLES = RECOVERY_CYC,
   parameter int MEM_ATTACH_CYCLES = MEM_ATTACH_CYC,
   parameter int INACTIVE_CYCLES = INACTIVE_CYC,
   parameter int STRAP_ATTACH_CYCLES = STRAP_ATTACH_CYC
) (
   input wire logic clock,
   input wire logic srst,
   // hardware reset pin, active low
   input wire logic hwReset_n,
   // configuration select straps
   input wire logic [1:0] cfgSel,
   // memory read engine reports done
   input wire logic memReadDone,
   // smbus code load finished
   input wire logic smbLoadDone,
   // upstream bus reset seen (level)
   input wire logic usbBusReset,
   // host enumeration events
   input wire logic setAddrValid,
   input wire logic [6:0] setAddrValue,
   input wire logic setConfigValid,
   // suspend request from link
   input wire logic suspendReq,
   // battery-charge enable per port
   input wire logic [NUM_PORTS-1:0] charge_port_enable,
   // host requests port power per port
   input wire logic [NUM_PORTS-1:0] portPowerReq,
   output logic [NUM_PORTS-1:0] downstream_port_power_en,
   output logic outputsActive,
   output logic memReadStart,
   output logic usbAttach,
   output logic operational,
   output logic [1:0] selectedPath,
   output logic [6:0] deviceAddr,
   output logic configured,
   output logic suspended,
   output logic ttFlush,
   output logic downstreamReset
);

   // sequencer state and its next value
   hrs_state_t state_reg, state_next;
   // shared delay counter
   logic [CNT_W-1:0] count_reg, count_next;
   // strap sample, held till the next hardware reset
   logic [1:0] path_reg, path_next;
   logic outAct_reg, outAct_next;
   logic attach_reg, attach_next;
   logic memStart_reg, memStart_next;
   logic oper_reg, oper_next;
   // enumeration state
   logic [6:0] addr_reg, addr_next;
   logic conf_reg, conf_next;
   logic susp_reg, susp_next;
   logic [NUM_PORTS-1:0] pwr_reg, pwr_next;
   logic flush_reg, flush_next;
   hrs_busrst_t busAct;

   // counter compare helper, used for every timed step
   function automatic logic reached(input logic [CNT_W-1:0] c, input int lim);
      reached = (c >= CNT_W'(lim - 1));
   endfunction : reached

   // start-up sequencing
   always_comb begin
      state_next = state_reg;
      count_next = count_reg + CNT_W'(1);
      path_next = path_reg;
      outAct_next = outAct_reg;
      attach_next = attach_reg;
      memStart_next = 1'b0;
      oper_next = oper_reg;
      case (state_reg)
         HRS_IN_RESET: begin
            // pin held low: everything idle
            count_next = '0;
            outAct_next = 1'b0;
            attach_next = 1'b0;
            oper_next = 1'b0;
            if (hwReset_n) begin
               path_next = cfgSel;
               state_next = (cfgSel == SEL_STRAP) ? HRS_STRAP_WAIT : HRS_RECOVER;
            end
         end
         HRS_STRAP_WAIT: begin
            // inactive outputs by deadline
            // one short: the exit edge from reset already counts a cycle
            if (reached(count_reg, INACTIVE_CYCLES - 1)) begin
               outAct_next = 1'b1;
            end
            if (reached(count_reg, STRAP_ATTACH_CYCLES)) begin
               oper_next = 1'b1;
               attach_next = 1'b1;
               state_next = HRS_ATTACHED;
            end
         end
         HRS_RECOVER: begin
            // operational within recovery time
            // one short: the exit edge from reset already counts a cycle
            if (reached(count_reg, RECOVERY_CYCLES - 1)) begin
               oper_next = 1'b1;
               outAct_next = 1'b1;
               count_next = '0;
               if (path_reg == SEL_MEMORY) begin
                  memStart_next = 1'b1;
                  state_next = HRS_MEM_READ;
               end else begin
                  state_next = HRS_SMB_WAIT;
               end
            end
         end
         HRS_MEM_READ: begin
            // saturate at the typical time; only the engine's done moves to attach
            if (reached(count_reg, MEM_ATTACH_CYCLES)) begin
               count_next = count_reg;
            end
            if (memReadDone) begin
               attach_next = 1'b1;
               state_next = HRS_ATTACHED;
            end
         end
         HRS_SMB_WAIT: begin
            // waits without limit for the load
            count_next = '0;
            if (smbLoadDone) begin
               attach_next = 1'b1;
               state_next = HRS_ATTACHED;
            end
         end
         HRS_ATTACHED: begin
            count_next = '0;
         end
         default: begin
            state_next = HRS_IN_RESET;
         end
      endcase
      // pin low always wins
      if (!hwReset_n) begin
         state_next = HRS_IN_RESET;
         count_next = '0;
         outAct_next = 1'b0;
         attach_next = 1'b0;
         oper_next = 1'b0;
         memStart_next = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= HRS_IN_RESET;
         count_reg <= '0;
         path_reg <= SEL_STRAP;
         outAct_reg <= 1'b0;
         attach_reg <= 1'b0;
         memStart_reg <= 1'b0;
         oper_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         path_reg <= path_next;
         outAct_reg <= outAct_next;
         attach_reg <= attach_next;
         memStart_reg <= memStart_next;
         oper_reg <= oper_next;
      end
   end

   // bus reset effects only act while attached
   always_comb begin
      busAct.addrClear = usbBusReset && attach_reg;
      busAct.unconfigure = usbBusReset && attach_reg;
      busAct.ttFlush = usbBusReset && attach_reg;
      busAct.wake = usbBusReset && attach_reg;
   end

   // enumeration and port power state
   always_comb begin
      addr_next = addr_reg;
      conf_next = conf_reg;
      susp_next = susp_reg;
      pwr_next = pwr_reg;
      flush_next = busAct.ttFlush;
      if (setAddrValid) begin
         addr_next = setAddrValue;
      end
      if (setConfigValid) begin
         conf_next = 1'b1;
      end
      if (conf_reg) begin
         pwr_next = portPowerReq | charge_port_enable;
      end
      if (suspendReq) begin
         susp_next = 1'b1;
      end
      if (busAct.addrClear) begin
         addr_next = ADDR_RESET;
      end
      if (busAct.unconfigure) begin
         conf_next = 1'b0;
      end
      if (busAct.addrClear) begin
         pwr_next = pwr_reg & charge_port_enable;
      end
      if (busAct.wake) begin
         susp_next = 1'b0;
      end
      // hardware reset: ports off unless charging
      if (!hwReset_n || !attach_reg) begin
         addr_next = ADDR_RESET;
         conf_next = 1'b0;
         susp_next = 1'b0;
         pwr_next = charge_port_enable;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         addr_reg <= ADDR_RESET;
         conf_reg <= 1'b0;
         susp_reg <= 1'b0;
         pwr_reg <= '0;
         flush_reg <= 1'b0;
      end else begin
         addr_reg <= addr_next;
         conf_reg <= conf_next;
         susp_reg <= susp_next;
         pwr_reg <= pwr_next;
         flush_reg <= flush_next;
      end
   end

   // outputs, all from flip-flops except downstreamReset, tied low
   assign downstream_port_power_en = pwr_reg;
   assign outputsActive = outAct_reg;
   assign memReadStart = memStart_reg;
   assign usbAttach = attach_reg;
   assign operational = oper_reg;
   assign selectedPath = path_reg;
   assign deviceAddr = addr_reg;
   assign configured = conf_reg;
   assign suspended = susp_reg;
   assign ttFlush = flush_reg;
   assign downstreamReset = 1'b0;

   // checks
   sequence s_busReset;
      usbBusReset && attach_reg;
   endsequence

   a_addr_cleared: assert property (@(posedge clock) disable iff (srst)
      s_busReset |=> deviceAddr == ADDR_RESET) else $error("address not cleared");
   a_unconfig_after: assert property (@(posedge clock) disable iff (srst)
      s_busReset |=> !configured) else $error("still configured");
   a_power_drop: assert property (@(posedge clock) disable iff (srst)
      s_busReset ##1 !usbBusReset |-> (downstream_port_power_en & ~$past(charge_port_enable)) == '0)
      else $error("port power kept");
   a_tt_flush: assert property (@(posedge clock) disable iff (srst)
      s_busReset |=> ttFlush) else $error("no flush");
   a_wake_up: assert property (@(posedge clock) disable iff (srst)
      s_busReset |=> !suspended) else $error("still suspended");
   a_no_forward: assert property (@(posedge clock) disable iff (srst)
      !downstreamReset) else $error("reset forwarded");
   a_path_held: assert property (@(posedge clock) disable iff (srst)
      state_reg != HRS_IN_RESET && hwReset_n |=> $stable(selectedPath)) else $error("path changed");
   a_smb_attach: assert property (@(posedge clock) disable iff (srst)
      state_reg == HRS_SMB_WAIT && smbLoadDone && hwReset_n |=> usbAttach) else $error("late attach");
   a_mem_start: assert property (@(posedge clock) disable iff (srst)
      memReadStart |-> operational && path_reg == SEL_MEMORY) else $error("early read");
   a_attach_oper: assert property (@(posedge clock) disable iff (srst)
      usbAttach |-> operational) else $error("attach before operational");
   a_outputs_inactive: assert property (@(posedge clock) disable iff (srst)
      state_reg == HRS_STRAP_WAIT && count_reg >= CNT_W'(INACTIVE_CYCLES - 1) |-> outputsActive)
      else $error("outputs late");
   a_recover_limit: assert property (@(posedge clock) disable iff (srst)
      state_reg == HRS_RECOVER |-> count_reg <= CNT_W'(RECOVERY_CYCLES - 2)) else $error("recovery too long");
endmodule : hrs_sequencer

// ===== include/hrs_pkg.sv
// Notes on behaviour
// - operational within 500 us of release
// - straps pick strap, memory or smbus path
// - strap mode: outputs inactive within 2 us
// - attach after configuration completes
// - memory mode: recover, then read memory
// - smbus load 2..1000 ms, attach at once
// - bus reset zeroes device address
// - bus reset returns to unconfigured
// - bus reset drops port power unless charging
// - bus reset flushes translator buffers
// - bus reset wakes a suspended hub
// - bus reset never forwarded downstream
package hrs_pkg;
   // clock period in ns
   localparam int CLK_PERIOD_NS = 8;
   // recovery time in us, longest time rounds down
   localparam int RECOVERY_US = 500;
   localparam int RECOVERY_CYC = (RECOVERY_US * 1000) / CLK_PERIOD_NS;
   // strap mode: outputs inactive, most time in ns (2 us), rounds down
   localparam int INACTIVE_NS = 2000;
   localparam int INACTIVE_CYC = INACTIVE_NS / CLK_PERIOD_NS;
   // strap mode attach, typical ns (3 us)
   localparam int STRAP_ATTACH_NS = 3000;
   localparam int STRAP_ATTACH_CYC = STRAP_ATTACH_NS / CLK_PERIOD_NS;
   // memory read time and attach delay, typical ms
   localparam int MEM_ATTACH_MS = 40;
   localparam int MEM_ATTACH_CYC = (MEM_ATTACH_MS * 1000000) / CLK_PERIOD_NS;
   // strap select encodings
   localparam logic [1:0] SEL_STRAP = 2'h0;
   localparam logic [1:0] SEL_MEMORY = 2'h1;
   localparam logic [1:0] SEL_SMBUS = 2'h2;
   // reset values
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam int CNT_W = 24;

   // start-up sequencer states
   typedef enum logic [2:0] {
      HRS_IN_RESET,
      HRS_RECOVER,
      HRS_STRAP_WAIT,
      HRS_MEM_READ,
      HRS_SMB_WAIT,
      HRS_ATTACHED
   } hrs_state_t;

   // bus reset side effects travel together
   typedef struct packed {
      logic addrClear;
      logic unconfigure;
      logic ttFlush;
      logic wake;
   } hrs_busrst_t;
endpackage : hrs_pkg

// ===== sim/hrs_host_model.sv
`timescale 1ns/100ps
module hrs_host_model
   import hrs_pkg::*;
#(
   // host wait after attach, scaled down
   parameter int HOST_WAIT = 30,
   // bus reset hold, scaled down
   parameter int RESET_HOLD = 12
) (
   input wire logic clock,
   input wire logic [1:0] selectedPath,
   input wire logic operational,
   input wire logic memReadStart,
   input wire logic usbAttach,
   input wire logic doBusReset,
   input wire logic [7:0] loadDelay,
   output logic memReadDone,
   output logic smbLoadDone,
   output logic usbBusReset
);
   // answers idle low until a start is seen
   initial begin
      memReadDone = 1'b0;
      smbLoadDone = 1'b0;
      usbBusReset = 1'b0;
   end
   always begin
      @(posedge memReadStart);
      repeat (loadDelay) @(negedge clock);
      memReadDone <= 1'b1;
      @(negedge clock);
      memReadDone <= 1'b0;
   end
   always begin
      @(posedge operational);
      // only the smbus straps wait for a code load
      if (selectedPath[1]) begin
         repeat (loadDelay) @(negedge clock);
         smbLoadDone <= 1'b1;
         @(negedge clock);
         smbLoadDone <= 1'b0;
      end
   end
   always begin
      @(posedge usbAttach);
      if (doBusReset) begin
         repeat (HOST_WAIT) @(negedge clock);
         usbBusReset <= 1'b1;
         repeat (RESET_HOLD) @(negedge clock);
         usbBusReset <= 1'b0;
      end
   end
endmodule : hrs_host_model

// ===== sim/hub_reset_config_sequencer_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module hub_reset_config_sequencer_tb;
   import hrs_pkg::*;
   // shortened counts handed to the design
   localparam int REC = 20;
   localparam int INACT = 5;
   localparam int STRAPA = 8;
   int n_fail = 0;
   int checked = 0;
   logic clock, srst, hwReset_n, memReadDone, smbLoadDone, usbBusReset;
   logic setAddrValid, setConfigValid, suspendReq, doBusReset;
   logic [1:0] cfgSel, selectedPath;
   logic [6:0] setAddrValue, deviceAddr;
   logic [3:0] chargeEn, portPowerReq, portPower;
   logic [7:0] loadDelay;
   logic outputsActive, memReadStart, usbAttach, operational, configured, suspended, ttFlush, downstreamReset;

   hrs_sequencer #(.NUM_PORTS(4), .RECOVERY_CYCLES(REC), .MEM_ATTACH_CYCLES(50),
      .INACTIVE_CYCLES(INACT), .STRAP_ATTACH_CYCLES(STRAPA)) dut (
      .clock(clock), .srst(srst), .hwReset_n(hwReset_n), .cfgSel(cfgSel),
      .memReadDone(memReadDone), .smbLoadDone(smbLoadDone), .usbBusReset(usbBusReset),
      .setAddrValid(setAddrValid), .setAddrValue(setAddrValue), .setConfigValid(setConfigValid),
      .suspendReq(suspendReq), .charge_port_enable(chargeEn), .portPowerReq(portPowerReq),
      .downstream_port_power_en(portPower), .outputsActive(outputsActive),
      .memReadStart(memReadStart), .usbAttach(usbAttach), .operational(operational),
      .selectedPath(selectedPath), .deviceAddr(deviceAddr), .configured(configured),
      .suspended(suspended), .ttFlush(ttFlush), .downstreamReset(downstreamReset));

   hrs_host_model host (.clock(clock), .selectedPath(selectedPath), .operational(operational),
      .memReadStart(memReadStart), .usbAttach(usbAttach), .doBusReset(doBusReset),
      .loadDelay(loadDelay), .memReadDone(memReadDone), .smbLoadDone(smbLoadDone),
      .usbBusReset(usbBusReset));

   // free-running 125 MHz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // single exit point with the verdict
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // bounded wait on one output, counts falling edges
   task automatic wait_sig(input int which, input int lim, output int n);
      logic s;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1 && n < lim) begin
         @(negedge clock);
         n++;
         case (which)
            0: s = outputsActive;
            1: s = operational;
            2: s = usbAttach;
            default: s = memReadStart;
         endcase
      end
   endtask : wait_sig

   // pin reset just past 1 us (130 cycles), straps set before release
   task automatic hw_start(input logic [1:0] sel, input logic [7:0] dly);
      hwReset_n = 1'b0;
      loadDelay = dly;
      cfgSel = sel;
      // hold pin low past 1 us
      repeat (130) @(negedge clock);
      hwReset_n = 1'b1;
   endtask : hw_start

   task automatic test_strap();
      int n, m;
      hw_start(SEL_STRAP, 8'h02);
      wait_sig(0, 40, n);
      `CHK(n >= INACT - 1 && n <= INACT, 1'b1)
      wait_sig(2, 40, m);
      `CHK(n + m >= STRAPA - 1 && n + m <= STRAPA + 2, 1'b1)
      `CHK(operational, 1'b1)
      `CHK(selectedPath, SEL_STRAP)
   endtask : test_strap

   task automatic test_mem();
      int n, m;
      hw_start(SEL_MEMORY, 8'h0f);
      wait_sig(3, 60, n);
      `CHK(n >= REC - 1 && n <= REC, 1'b1)
      `CHK(usbAttach, 1'b0)
      wait_sig(2, 60, m);
      `CHK(m >= 15 && m <= 19, 1'b1)
      `CHK(operational, 1'b1)
      `CHK(selectedPath, SEL_MEMORY)
   endtask : test_mem

   // straps move after capture; the smbus path must hold
   task automatic test_smb();
      int n, m;
      hw_start(SEL_SMBUS, 8'h28);
      repeat (3) @(negedge clock);
      cfgSel = SEL_STRAP;
      repeat (STRAPA + 3) @(negedge clock);
      `CHK(usbAttach, 1'b0)
      wait_sig(1, 40, n);
      `CHK(n + STRAPA + 6 <= REC, 1'b1)
      wait_sig(2, 80, m);
      `CHK(m >= 39 && m <= 43, 1'b1)
      `CHK(selectedPath, SEL_SMBUS)
   endtask : test_smb

   // enumerate, suspend, then take an upstream bus reset
   task automatic test_busrst();
      int n, m;
      doBusReset = 1'b1;
      chargeEn = 4'h5;
      portPowerReq = 4'hf;
      hw_start(SEL_STRAP, 8'h02);
      wait_sig(2, 40, n);
      setAddrValue = 7'h2a;
      setAddrValid = 1'b1;
      @(negedge clock);
      setAddrValid = 1'b0;
      setConfigValid = 1'b1;
      @(negedge clock);
      setConfigValid = 1'b0;
      suspendReq = 1'b1;
      @(negedge clock);
      suspendReq = 1'b0;
      @(negedge clock);
      `CHK({deviceAddr, configured, suspended, portPower}, {7'h2a, 2'h3, 4'hf})
      m = 0;
      while (usbBusReset !== 1'b1 && m < 60) begin
         @(negedge clock);
         m++;
      end
      repeat (2) @(negedge clock);
      `CHK(deviceAddr, 7'h00)
      `CHK(configured, 1'b0)
      `CHK(portPower, 4'h5)
      `CHK(ttFlush, 1'b1)
      `CHK(suspended, 1'b0)
      `CHK(downstreamReset, 1'b0)
      repeat (14) @(negedge clock);
      `CHK({configured, portPower, downstreamReset}, 6'h0a)
      doBusReset = 1'b0;
   endtask : test_busrst

   // unused strap code 3 must take the smbus path
   task automatic test_sel3();
      int n;
      hw_start(2'h3, 8'h04);
      wait_sig(2, 60, n);
      `CHK(n >= REC + 4 && n <= REC + 5, 1'b1)
      `CHK(selectedPath, 2'h3)
   endtask : test_sel3

   // main sequence, inputs change on falling edges
   initial begin
      srst = 1'b1;
      hwReset_n = 1'b0;
      cfgSel = SEL_STRAP;
      setAddrValid = 1'b0;
      setAddrValue = 7'h00;
      setConfigValid = 1'b0;
      suspendReq = 1'b0;
      chargeEn = 4'h0;
      portPowerReq = 4'h0;
      doBusReset = 1'b0;
      loadDelay = 8'h02;
      repeat (6) @(negedge clock);
      srst = 1'b0;
      test_strap();
      test_mem();
      test_smb();
      test_busrst();
      test_sel3();
      report_and_stop();
   end

   // whole run needs about 850 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule : hub_reset_config_sequencer_tb
